// ---- vic_pkg.sv ----
// Shared constants and the default code table of the vectored interrupt controller pair.
// Assumes one 20 MHz system clock and a synchronous active-high reset on both ends.
package vic_pkg;

	localparam int NUM_SRC = 20;
	localparam int CODE_W = 6;

	// Device register indices on the link register port
	localparam logic [3:0] OFS_FIXED_VECTOR = 4'h0;
	localparam logic [3:0] OFS_MODIFIED_VECTOR = 4'h1;
	localparam logic [3:0] OFS_INTERRUPT_CONTROL = 4'h2;
	localparam logic [3:0] OFS_SERIAL_STATUS = 4'h3;
	localparam logic [3:0] OFS_DMA_STATUS = 4'h4;
	localparam logic [3:0] OFS_TIMER_STATUS = 4'h5;
	localparam logic [3:0] OFS_SERIAL_ENABLE = 4'h6;
	localparam logic [3:0] OFS_DMA_ENABLE = 4'h7;
	localparam logic [3:0] OFS_TIMER_ENABLE = 4'h8;

	// Field positions of interrupt_control
	localparam int POS_PRIORITY_ORDER = 7;
	localparam int POS_ACK_TYPE_HI = 6;
	localparam int POS_ACK_TYPE_LO = 5;
	localparam int POS_VECTOR_SELECT = 4;

	// Writable masks: reserved positions are forced to zero
	localparam logic [7:0] MASK_MODIFIED_VECTOR = 8'hc0;
	localparam logic [7:0] MASK_INTERRUPT_CONTROL = 8'hf0;
	localparam logic [7:0] MASK_TIMER = 8'hf0;

	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [5:0] RST_CODE = 6'h00;

	// Acknowledge-type field encodings
	localparam logic [1:0] ACK_NONE = 2'h0;
	localparam logic [1:0] ACK_SINGLE = 2'h1;
	localparam logic [1:0] ACK_DOUBLE = 2'h2;
	localparam logic [1:0] ACK_RESERVED = 2'h3;

	// Host controller register offsets on the user port
	localparam logic [2:0] HOFS_TARGET = 3'h0;
	localparam logic [2:0] HOFS_WRITE = 3'h1;
	localparam logic [2:0] HOFS_READ = 3'h2;
	localparam logic [2:0] HOFS_READ_DATA = 3'h3;
	localparam logic [2:0] HOFS_ACK = 3'h4;
	localparam logic [2:0] HOFS_VECTOR = 3'h5;

	// Length of one low acknowledge strobe, in clock cycles
	localparam int ACK_LOW_CYCLES = 4;

	// Default source code table: each source coded by its own index
	function automatic logic [NUM_SRC*CODE_W-1:0] default_codes();
		logic [NUM_SRC*CODE_W-1:0] t;
		t = '0;
		for (int i = 0; i < NUM_SRC; i++)
		begin
			t[i*CODE_W +: CODE_W] = CODE_W'(i);
		end
		return t;
	endfunction

endpackage

// ---- vic_if.sv ----
// Link between the interrupt controller and the host processor side.
// Assumes both ends share sys_clk; the vector bus is driven by the device alone, qualified by vec_oe_n.
`timescale 1ns/1ps
interface vic_if
(
	input wire logic sys_clk
);
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_we;
	logic reg_re;
	logic [7:0] reg_rdata;
	logic irq_n;
	logic irq_ack_n;
	logic [15:0] vec_out;
	logic vec_oe_n;

	modport dev_mp
	(
		input reg_addr, reg_wdata, reg_we, reg_re, irq_ack_n,
		output reg_rdata, irq_n, vec_out, vec_oe_n
	);

	modport host_mp
	(
		output reg_addr, reg_wdata, reg_we, reg_re, irq_ack_n,
		input reg_rdata, irq_n, vec_out, vec_oe_n
	);
endinterface

// ---- vic_device.sv ----
// Interrupt controller end: status, enables, priority ranking, vector answer.
// Assumes request lines come from logic on sys_clk and the host keeps reserved bits zero.
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps

module vic_device
#(
	parameter logic [vic_pkg::NUM_SRC*vic_pkg::CODE_W-1:0] SRC_CODE_TABLE = vic_pkg::default_codes()
)
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	vic_if.dev_mp link,
	input wire logic [7:0] serial_req,
	input wire logic [7:0] dma_req,
	input wire logic [3:0] timer_req
);
	import vic_pkg::*;

	typedef struct packed {
		logic [7:0] fixed_vector;
		logic [1:0] mod_top;
		logic priority_order_select;
		logic [1:0] ack_type;
		logic vector_select;
		logic [7:0] serial_en;
		logic [7:0] dma_en;
		logic [3:0] timer_en;
		logic [7:0] serial_st;
		logic [7:0] dma_st;
		logic [3:0] timer_st;
		logic [7:0] rdata;
		logic irq_n;
		logic ack_prev;
		logic ack_armed;
		logic drive;
		logic [7:0] vec;
	} vic_dev_state_t;

	localparam vic_dev_state_t STATE_RESET = '{
		fixed_vector: RST_BYTE,
		mod_top: 2'h0,
		priority_order_select: 1'b0,
		ack_type: ACK_NONE,
		vector_select: 1'b0,
		serial_en: RST_BYTE,
		dma_en: RST_BYTE,
		timer_en: 4'h0,
		serial_st: RST_BYTE,
		dma_st: RST_BYTE,
		timer_st: 4'h0,
		rdata: RST_BYTE,
		irq_n: 1'b1,
		ack_prev: 1'b1,
		ack_armed: 1'b0,
		drive: 1'b0,
		vec: RST_BYTE
	};

	vic_dev_state_t s_reg;
	vic_dev_state_t s_next;

	// Rank position to source identity; identities are serial 0-7, DMA 8-15, timers 16-19
	function automatic int rank_to_src(input int rank, input logic dma_first);
		int src;
		src = rank;
		if (dma_first && rank < 8)
		begin
			src = rank + 8;
		end
		else if (dma_first && rank < 16)
		begin
			src = rank - 8;
		end
		return src;
	endfunction

	// Whole next-state computation in one place
	always_comb
	begin
		logic [NUM_SRC-1:0] pend;
		logic found;
		logic [5:0] code;
		logic [7:0] sel_vec;
		logic ack_fall;
		int src;
		pend = '0;
		found = 1'b0;
		code = RST_CODE;
		sel_vec = RST_BYTE;
		ack_fall = 1'b0;
		src = 0;
		s_next = s_reg;

		// Status mirrors the source lines; writes never touch it
		s_next.serial_st = serial_req;
		s_next.dma_st = dma_req;
		s_next.timer_st = timer_req;

		// Enabled pending requests, indexed by source identity
		pend = {s_reg.timer_st & s_reg.timer_en, s_reg.dma_st & s_reg.dma_en,
			s_reg.serial_st & s_reg.serial_en};
		s_next.irq_n = ~(|pend);

		// Highest-ranked enabled source wins the code field
		for (int r = 0; r < NUM_SRC; r++)
		begin
			src = rank_to_src(r, s_reg.priority_order_select);
			if (!found && pend[src])
			begin
				found = 1'b1;
				code = SRC_CODE_TABLE[src*CODE_W +: CODE_W];
			end
		end

		// Register writes; reserved positions are masked off
		if (link.reg_we)
		begin
			case (link.reg_addr)
				OFS_FIXED_VECTOR: s_next.fixed_vector = link.reg_wdata;
				OFS_MODIFIED_VECTOR: s_next.mod_top = link.reg_wdata[7:6];
				OFS_INTERRUPT_CONTROL:
				begin
					s_next.priority_order_select = link.reg_wdata[POS_PRIORITY_ORDER];
					s_next.ack_type = {link.reg_wdata[POS_ACK_TYPE_HI],
						link.reg_wdata[POS_ACK_TYPE_LO]};
					s_next.vector_select = link.reg_wdata[POS_VECTOR_SELECT];
				end
				OFS_SERIAL_ENABLE: s_next.serial_en = link.reg_wdata;
				OFS_DMA_ENABLE: s_next.dma_en = link.reg_wdata;
				OFS_TIMER_ENABLE: s_next.timer_en = link.reg_wdata[7:4];
				default: ;
			endcase
		end

		// Read data stands for exactly one cycle after the strobe
		s_next.rdata = RST_BYTE;
		if (link.reg_re)
		begin
			case (link.reg_addr)
				OFS_FIXED_VECTOR: s_next.rdata = s_reg.fixed_vector;
				OFS_MODIFIED_VECTOR: s_next.rdata = {s_reg.mod_top, RST_CODE};
				OFS_INTERRUPT_CONTROL: s_next.rdata = {s_reg.priority_order_select,
					s_reg.ack_type, s_reg.vector_select, 4'h0};
				OFS_SERIAL_STATUS: s_next.rdata = s_reg.serial_st;
				OFS_DMA_STATUS: s_next.rdata = s_reg.dma_st;
				OFS_TIMER_STATUS: s_next.rdata = {s_reg.timer_st, 4'h0};
				OFS_SERIAL_ENABLE: s_next.rdata = s_reg.serial_en;
				OFS_DMA_ENABLE: s_next.rdata = s_reg.dma_en;
				OFS_TIMER_ENABLE: s_next.rdata = {s_reg.timer_en, 4'h0};
				default: s_next.rdata = RST_BYTE;
			endcase
		end

		// Vector chosen at the acknowledge edge; the code is frozen from then on
		sel_vec = s_reg.vector_select ? {s_reg.mod_top, code} : s_reg.fixed_vector;
		ack_fall = !link.irq_ack_n && s_reg.ack_prev;
		s_next.ack_prev = link.irq_ack_n;

		// Acknowledge handling: the bus is held only while the strobe stays low
		if (link.irq_ack_n)
		begin
			s_next.drive = 1'b0;
		end
		else if (ack_fall && !s_reg.irq_n)
		begin
			case (s_reg.ack_type)
				ACK_SINGLE:
				begin
					s_next.drive = 1'b1;
					s_next.vec = sel_vec;
				end
				ACK_DOUBLE:
				begin
					if (s_reg.ack_armed)
					begin
						s_next.drive = 1'b1;
						s_next.vec = sel_vec;
						s_next.ack_armed = 1'b0;
					end
					else
					begin
						s_next.ack_armed = 1'b1;
					end
				end
				// No-acknowledge and the reserved code never drive
				default: s_next.drive = 1'b0;
			endcase
		end
	end

	// Single state register
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			s_reg <= STATE_RESET;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from flip-flops; upper byte is don't-care, driven zero
	assign link.reg_rdata = s_reg.rdata;
	assign link.irq_n = s_reg.irq_n;
	assign link.vec_out = {RST_BYTE, s_reg.vec};
	assign link.vec_oe_n = ~s_reg.drive;

endmodule

// ---- vic_host.sv ----
// Host end: turns software commands into register accesses and acknowledge strobes.
// Assumes the device shares sys_clk, so link inputs need no synchroniser.
`timescale 1ns/1ps
module vic_host
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	vic_if.host_mp link,
	input wire logic [2:0] usr_addr,
	input wire logic [7:0] usr_wdata,
	input wire logic usr_we,
	input wire logic usr_re,
	output logic [7:0] usr_rdata
);
	import vic_pkg::*;

	typedef enum {H_IDLE, H_ACK_LOW} vic_host_st_t;

	typedef struct packed {
		vic_host_st_t st;
		logic [3:0] target;
		logic [7:0] wdata;
		logic we;
		logic re;
		logic read_pend;
		logic [7:0] read_data;
		logic ack_n;
		logic [2:0] ack_cnt;
		logic vec_valid;
		logic [7:0] vector;
		logic [7:0] rdata;
	} vic_host_state_t;

	vic_host_state_t h_reg;
	vic_host_state_t h_next;

	// Reserved positions cleared before reaching the device
	function automatic logic [7:0] clean_write(input logic [3:0] a, input logic [7:0] d);
		logic [7:0] r;
		r = d;
		case (a)
			OFS_MODIFIED_VECTOR: r = d & MASK_MODIFIED_VECTOR;
			OFS_INTERRUPT_CONTROL:
			begin
				r = d & MASK_INTERRUPT_CONTROL;
				if (r[POS_ACK_TYPE_HI] && r[POS_ACK_TYPE_LO])
				begin
					r[POS_ACK_TYPE_HI] = 1'b0;
					r[POS_ACK_TYPE_LO] = 1'b0;
				end
			end
			OFS_TIMER_STATUS, OFS_TIMER_ENABLE: r = d & MASK_TIMER;
			default: r = d;
		endcase
		return r;
	endfunction

	// Next state of the whole host
	always_comb
	begin
		h_next = h_reg;
		h_next.we = 1'b0;
		h_next.re = 1'b0;
		h_next.read_pend = 1'b0;

		// Device answers one cycle after its read strobe
		if (h_reg.read_pend)
		begin
			h_next.read_data = link.reg_rdata;
		end

		if (usr_we)
		begin
			case (usr_addr)
				HOFS_TARGET: h_next.target = usr_wdata[3:0];
				HOFS_WRITE:
				begin
					h_next.wdata = clean_write(h_reg.target, usr_wdata);
					h_next.we = 1'b1;
				end
				HOFS_READ:
				begin
					h_next.re = 1'b1;
				end
				HOFS_ACK:
				begin
					if (h_reg.st == H_IDLE && usr_wdata[0])
					begin
						h_next.st = H_ACK_LOW;
						h_next.ack_n = 1'b0;
						h_next.ack_cnt = 3'(ACK_LOW_CYCLES - 1);
						h_next.vec_valid = 1'b0;
					end
				end
				default: ;
			endcase
		end
		h_next.read_pend = h_reg.re;

		// Acknowledge strobe; the vector is caught whenever the device drives while the strobe is low
		case (h_reg.st)
			H_IDLE: ;
			H_ACK_LOW:
			begin
				if (!link.vec_oe_n)
				begin
					h_next.vector = link.vec_out[7:0];
					h_next.vec_valid = 1'b1;
				end
				if (h_reg.ack_cnt == 3'h0)
				begin
					h_next.ack_n = 1'b1;
					h_next.st = H_IDLE;
				end
				else
				begin
					h_next.ack_cnt = h_reg.ack_cnt - 3'h1;
				end
			end
			default: h_next.st = H_IDLE;
		endcase

		// User read data, one cycle after the strobe
		h_next.rdata = RST_BYTE;
		if (usr_re)
		begin
			case (usr_addr)
				HOFS_TARGET: h_next.rdata = {4'h0, h_reg.target};
				HOFS_READ_DATA: h_next.rdata = h_reg.read_data;
				HOFS_ACK: h_next.rdata = {5'h0, h_reg.vec_valid,
					h_reg.st == H_ACK_LOW, ~link.irq_n};
				HOFS_VECTOR: h_next.rdata = h_reg.vector;
				default: h_next.rdata = RST_BYTE;
			endcase
		end
	end

	// Single state register
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			h_reg <= '{st: H_IDLE, target: 4'h0, wdata: RST_BYTE, we: 1'b0, re: 1'b0,
				read_pend: 1'b0, read_data: RST_BYTE, ack_n: 1'b1, ack_cnt: 3'h0,
				vec_valid: 1'b0, vector: RST_BYTE, rdata: RST_BYTE};
		end
		else
		begin
			h_reg <= h_next;
		end
	end

	assign link.reg_addr = h_reg.target;
	assign link.reg_wdata = h_reg.wdata;
	assign link.reg_we = h_reg.we;
	assign link.reg_re = h_reg.re;
	assign link.irq_ack_n = h_reg.ack_n;
	assign usr_rdata = h_reg.rdata;

endmodule

// ---- vic_checker.sv ----
// Checker of the controller link: register answers and vector strobes.
// Assumes it sees only the link signals and the host never sends type 11.
`timescale 1ns/1ps
module vic_checker
import vic_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	input wire logic [7:0] reg_rdata,
	input wire logic irq_n,
	input wire logic irq_ack_n,
	input wire logic [15:0] vec_out,
	input wire logic vec_oe_n
);
	logic [7:0] fix_reg;
	logic [7:0] mod_reg;
	logic [7:0] ctl_reg;
	logic ack_reg;
	logic arm_reg;
	logic qf;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// Qualifying acknowledge: high at the last edge, low now, request active
	assign qf = ack_reg && !irq_ack_n && !irq_n;
	// Shadows of written state; the double-ack arm only counts under type 10
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			fix_reg <= RST_BYTE;
			mod_reg <= RST_BYTE;
			ctl_reg <= RST_BYTE;
			ack_reg <= 1'b1;
			arm_reg <= 1'b0;
		end
		else
		begin
			ack_reg <= irq_ack_n;
			if (reg_we && reg_addr == OFS_FIXED_VECTOR)
				fix_reg <= reg_wdata;
			if (reg_we && reg_addr == OFS_MODIFIED_VECTOR)
				mod_reg <= reg_wdata & MASK_MODIFIED_VECTOR;
			if (reg_we && reg_addr == OFS_INTERRUPT_CONTROL)
				ctl_reg <= reg_wdata & MASK_INTERRUPT_CONTROL;
			if (qf && ctl_reg[6:5] == ACK_DOUBLE)
				arm_reg <= !arm_reg;
		end
	end
	fix_rd_a: assert property (
		$past(reg_re) && $past(reg_addr) == OFS_FIXED_VECTOR |-> reg_rdata == fix_reg)
		else $error("fixed vector read wrong");
	mod_rd_a: assert property (
		$past(reg_re) && $past(reg_addr) == OFS_MODIFIED_VECTOR |-> reg_rdata == mod_reg)
		else $error("modified vector read wrong");
	ctl_rd_a: assert property (
		$past(reg_re) && $past(reg_addr) == OFS_INTERRUPT_CONTROL |-> reg_rdata == ctl_reg)
		else $error("control read wrong");
	timer_low_a: assert property (
		$past(reg_re) && $past(reg_addr) == OFS_TIMER_STATUS |-> reg_rdata[3:0] == 4'h0)
		else $error("timer status low bits set");
	fixed_out_a: assert property (
		!vec_oe_n && !ctl_reg[POS_VECTOR_SELECT] |-> vec_out[7:0] == fix_reg)
		else $error("fixed vector not driven");
	mod_out_a: assert property (
		!vec_oe_n && ctl_reg[POS_VECTOR_SELECT] |-> vec_out[7:6] == mod_reg[7:6])
		else $error("modified vector top bits wrong");
	none_quiet_a: assert property (ctl_reg[6:5] == ACK_NONE |-> vec_oe_n)
		else $error("vector driven with type 00");
	single_drive_a: assert property (
		qf && ctl_reg[6:5] == ACK_SINGLE |=> !vec_oe_n && vec_out[15:8] == 8'h00)
		else $error("single acknowledge not answered");
	double_first_a: assert property (
		qf && ctl_reg[6:5] == ACK_DOUBLE && !arm_reg |=> vec_oe_n)
		else $error("first double acknowledge answered");
	double_second_a: assert property (
		qf && ctl_reg[6:5] == ACK_DOUBLE && arm_reg |=> !vec_oe_n)
		else $error("second double acknowledge not answered");
	no_req_a: assert property ($fell(vec_oe_n) |-> $past(qf))
		else $error("vector without qualifying acknowledge");
	release_a: assert property ($rose(irq_ack_n) |=> vec_oe_n)
		else $error("vector held after acknowledge");
	cover property (qf && ctl_reg[6:5] == ACK_SINGLE);
	cover property (qf && ctl_reg[6:5] == ACK_DOUBLE && arm_reg);
	cover property (qf && ctl_reg[6:5] == ACK_NONE);
	// Acknowledge falling while no request is active
	cover property (ack_reg && !irq_ack_n && irq_n);
endmodule

// ---- vectored_interrupt_controller_tb_top.sv ----
// Testbench of the controller pair: software on the host port, requests from the bench.
// Assumes the default source table, so a source code equals its index.
`timescale 1ns/1ps
module vectored_interrupt_controller_tb_top;
	import vic_pkg::*;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [2:0] usr_addr = 3'h0;
	logic [7:0] usr_wdata = 8'h00;
	logic usr_we = 1'b0;
	logic usr_re = 1'b0;
	logic [7:0] usr_rdata;
	logic [7:0] serial_req = 8'h00;
	logic [7:0] dma_req = 8'h00;
	logic [3:0] timer_req = 4'h0;
	logic [7:0] rd;
	int bad_count = 0;
	int n_tests = 0;
	// Priority cases: requests, order bit, expected winning code
	logic [7:0] cs [5] = '{8'h0c, 8'h08, 8'h08, 8'h10, 8'h00};
	logic [7:0] cd [5] = '{8'h00, 8'h01, 8'h01, 8'h80, 8'h00};
	logic [3:0] ct [5] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'hc};
	logic cp [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
	logic [5:0] cc [5] = '{6'h02, 6'h03, 6'h08, 6'h0f, 6'h12};
	vic_if link (.sys_clk(sys_clk));
	vic_device i_vic_device (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(link),
		.serial_req(serial_req), .dma_req(dma_req), .timer_req(timer_req));
	vic_host i_vic_host (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(link),
		.usr_addr(usr_addr), .usr_wdata(usr_wdata), .usr_we(usr_we), .usr_re(usr_re),
		.usr_rdata(usr_rdata));
	vic_checker i_vic_checker (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .reg_we(link.reg_we),
		.reg_re(link.reg_re), .reg_rdata(link.reg_rdata), .irq_n(link.irq_n),
		.irq_ack_n(link.irq_ack_n), .vec_out(link.vec_out), .vec_oe_n(link.vec_oe_n));
	// 20 MHz system clock
	always #25 sys_clk = ~sys_clk;
	task automatic conclude();
		$display("comparisons=%0d mismatches=%0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// A gap cycle between strobes keeps each strobe a single clean pulse
	task automatic uw(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		usr_addr <= a;
		usr_wdata <= d;
		usr_we <= 1'b1;
		@(posedge sys_clk);
		usr_we <= 1'b0;
	endtask
	task automatic ur(input logic [2:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		usr_addr <= a;
		usr_re <= 1'b1;
		@(posedge sys_clk);
		usr_re <= 1'b0;
		#1 d = usr_rdata;
	endtask
	task automatic dw(input logic [3:0] i, input logic [7:0] d);
		uw(HOFS_TARGET, {4'h0, i});
		uw(HOFS_WRITE, d);
	endtask
	task automatic dr(input logic [3:0] i, input logic [7:0] exp);
		logic [7:0] d;
		uw(HOFS_TARGET, {4'h0, i});
		uw(HOFS_READ, 8'h00);
		repeat (3) @(posedge sys_clk);
		ur(HOFS_READ_DATA, d);
		chk(d, exp);
	endtask
	// One acknowledge strobe; watches the link for a driven vector
	task automatic ackc(input logic exp_drv, input logic [7:0] exp_vec);
		logic drv;
		logic [7:0] v;
		drv = 1'b0;
		v = 8'h00;
		uw(HOFS_ACK, 8'h01);
		repeat (10)
		begin
			@(posedge sys_clk);
			#1;
			if (link.vec_oe_n === 1'b0)
			begin
				drv = 1'b1;
				v = link.vec_out[7:0];
			end
		end
		chk({7'h0, drv}, {7'h0, exp_drv});
		if (exp_drv)
		begin
			chk(v, exp_vec);
			ur(HOFS_VECTOR, v);
			chk(v, exp_vec);
		end
	endtask
	initial
	begin
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'b0;
		// All registers start at zero; index 9 is unmapped
		for (int i = 0; i < 10; i++)
			dr(4'(i), RST_BYTE);
		dw(OFS_FIXED_VECTOR, 8'ha5);
		dr(OFS_FIXED_VECTOR, 8'ha5);
		// Reserved positions written as ones must come back as zero
		dw(OFS_MODIFIED_VECTOR, 8'h8f);
		dw(OFS_TIMER_ENABLE, 8'hff);
		dr(OFS_TIMER_ENABLE, 8'hf0);
		dw(OFS_TIMER_STATUS, 8'hff);
		dr(OFS_TIMER_STATUS, 8'h00);
		@(posedge sys_clk);
		serial_req <= 8'h5a;
		dma_req <= 8'h3c;
		timer_req <= 4'h9;
		dr(OFS_SERIAL_STATUS, 8'h5a);
		dr(OFS_DMA_STATUS, 8'h3c);
		dr(OFS_TIMER_STATUS, 8'h90);
		// Timer enables are already set, so the timer requests alone pull the line low
		chk({7'h0, link.irq_n}, 8'h00);
		dr(OFS_MODIFIED_VECTOR, 8'h80);
		dw(OFS_SERIAL_ENABLE, 8'hff);
		dr(OFS_SERIAL_ENABLE, 8'hff);
		dw(OFS_DMA_ENABLE, 8'hff);
		dr(OFS_DMA_ENABLE, 8'hff);
		chk({7'h0, link.irq_n}, 8'h00);
		// Ranking, with the serial and DMA order swapped by the order bit
		for (int k = 0; k < 5; k++)
		begin
			@(posedge sys_clk);
			serial_req <= cs[k];
			dma_req <= cd[k];
			timer_req <= ct[k];
			dw(OFS_INTERRUPT_CONTROL, {cp[k], ACK_SINGLE, 1'b1, 4'h0});
			ackc(1'b1, {2'b10, cc[k]});
		end
		dr(OFS_INTERRUPT_CONTROL, 8'h30);
		// Acknowledge types with source 3 pending
		@(posedge sys_clk);
		serial_req <= 8'h08;
		timer_req <= 4'h0;
		dw(OFS_INTERRUPT_CONTROL, 8'h00);
		ackc(1'b0, 8'h00);
		dw(OFS_INTERRUPT_CONTROL, 8'h2f);
		dr(OFS_INTERRUPT_CONTROL, 8'h20);
		ackc(1'b1, 8'ha5);
		dw(OFS_INTERRUPT_CONTROL, 8'h50);
		ackc(1'b0, 8'h00);
		ackc(1'b1, 8'h83);
		// The reserved type becomes no acknowledge before it reaches the device
		dw(OFS_INTERRUPT_CONTROL, 8'h70);
		dr(OFS_INTERRUPT_CONTROL, 8'h10);
		ackc(1'b0, 8'h00);
		// A masked request raises nothing and gets no vector
		dw(OFS_INTERRUPT_CONTROL, 8'h20);
		dw(OFS_SERIAL_ENABLE, 8'h00);
		repeat (3) @(posedge sys_clk);
		// Look after the edge, once the request flop has settled
		#1;
		chk({7'h0, link.irq_n}, 8'h01);
		ackc(1'b0, 8'h00);
		dr(OFS_SERIAL_STATUS, 8'h08);
		conclude();
	end
	// Watchdog well beyond the expected run of about 440 cycles
	initial
	begin
		repeat (6000) @(posedge sys_clk);
		bad_count++;
		conclude();
	end
endmodule
